// [bench/spi_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic clk,
	input wire logic miso,
	output logic sclk,
	output logic csb_n,
	output logic mosi
);
	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
		mosi = 1'b0;
	end
	// ten clk a half keeps well clear of the synchroniser minimum
	task automatic half();
		repeat (10) @(posedge clk);
	endtask
	task automatic xfer(input logic rw, input logic [14:0] a, input int n, input logic lsb,
		inout logic [15:0] d);
		logic [31:0] sh;
		int k;
		sh = {rw, a, d[7:0], d[15:8]};
		@(posedge clk);
		csb_n <= 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			// lsb-first reverses the header and each byte, not the byte order
			k = lsb ? ((i < 16) ? 16 + i : 24 - i + 2 * ((i - 16) % 8)) : 31 - i;
			mosi <= sh[k];
			half();
			if (i > 15) sh[k] = miso;
			sclk <= 1'b1;
			half();
			sclk <= 1'b0;
		end
		half();
		csb_n <= 1'b1;
		mosi <= ~mosi;
		d = {sh[7:0], sh[15:8]};
		half();
	endtask
endmodule
`default_nettype wire

// [bench/synth_config_and_vco_cal_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module synth_config_and_vco_cal_control_tb_top;
	logic clk, srst, sclk, csb_n, mosi, so, soe, sdo, sdo_oe, dbg, busy, core;
	logic lk, ohl, dbl, pol, ofd, cmode, win, lsb_mode;
	logic [1:0] cexp;
	logic [3:0] pcs;
	logic [2:0] lwp, odiv, bias;
	logic [11:0] n_int;
	logic [5:0] r_div;
	logic [8:0] band;
	logic [15:0] d;
	logic [2:0] rc = 3'h0;
	logic rclk = 1'b0;
	int bad_count = 0;
	int checks = 0;
	// shared data wire: device wins while it drives
	wire sio = soe ? so : mosi;
	// four-wire reads return on sdo only; a silent sdo leaves the host its own line
	spi_host_model host_u (.clk(clk), .miso(sdo_oe ? sdo : sio), .sclk(sclk), .csb_n(csb_n),
		.mosi(mosi));
	synth_config_and_vco_cal_control dut_u (.clk(clk), .srst(srst), .sclk(sclk), .csb_n(csb_n),
		.sdio_in(sio), .sdio_out(so), .sdio_oe(soe), .sdo(sdo), .sdo_oe(sdo_oe), .rclk(rclk),
		.phase_in_window(win), .vco_fast(1'b1), .temp_code(9'h1A5),
		.lock_indicator_pin(lk), .debug_out_pin(dbg), .output_high_level_sel(ohl),
		.lock_window_profile(lwp), .n_int(n_int), .r_div(r_div),
		.reference_doubler_enable(dbl), .pump_current_select(pcs),
		.output_divide_ratio(odiv), .output_polarity_invert(pol),
		.offset_current_direction(ofd), .cal_clock_divide_exponent(cexp),
		.cal_clock_halving_mode(cmode), .vco_core_sel(core),
		.vco_band_sel(band), .vco_bias_sel(bias), .cal_state_busy_flag(busy));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// reference tick every eight clk, slow against clk
	always @(posedge clk) begin
		rc <= rc + 3'h1;
		rclk <= rc[2];
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		d = {8'h00, v};
		host_u.xfer(1'b0, {7'h00, a}, 1, lsb_mode, d);
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		d = 16'h0000;
		host_u.xfer(1'b1, {7'h00, a}, n, lsb_mode, d);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// status polling with a bound; running out ends the run
	task automatic wait_clear(input int b);
		for (int i = 0; i < 60; i++) begin
			rd(8'h58, 1);
			if (d[b] === 1'b0) return;
		end
		bad_count++;
		$display("mismatch status_poll expected 0 seen 1");
		conclude();
	endtask
	initial begin
		srst = 1'b1;
		win = 1'b0;
		lsb_mode = 1'b0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		rd(8'h58, 1);
		chk("status_reset", d, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			wr(8'h02, 8'(c << 5));
			chk("lock_window", {13'h0, lwp}, 16'(c));
		end
		$display("test lock_window done");
		// code 1 needs 35 reference ticks in window, eight clk apiece
		wr(8'h2D, 8'h30);
		wr(8'h2C, 8'h01);
		wr(8'h2E, 8'h10);
		win <= 1'b1;
		repeat (240) @(posedge clk);
		chk("lock_early", {15'h0, lk}, 16'h0000);
		repeat (64) @(posedge clk);
		chk("lock_set", {15'h0, lk}, 16'h0001);
		chk("debug_lock", {15'h0, dbg}, 16'h0001);
		rd(8'h58, 1);
		chk("status_lock", d, 16'h0001);
		win <= 1'b0;
		repeat (6) @(posedge clk);
		chk("lock_drop", {14'h0, lk, dbg}, 16'h0000);
		$display("test lock_detect done");
		wr(8'h20, 8'h45);
		wr(8'h21, 8'h07);
		wr(8'h11, 8'h43);
		chk("r_div_held", {10'h0, r_div}, 16'h0000);
		chk("pump_held", {11'h0, dbl, pcs}, 16'h0000);
		chk("odiv_direct", {13'h0, odiv}, 16'h0002);
		wr(8'h22, 8'h15);
		wr(8'h11, 8'h33);
		chk("odiv_held", {13'h0, odiv}, 16'h0002);
		chk("pol_ofd_held", {14'h0, pol, ofd}, 16'h0000);
		wr(8'h30, 8'h06);
		chk("cal_div_direct", {13'h0, cexp, cmode}, 16'h0005);
		wr(8'h31, 8'h02);
		wr(8'h33, 8'h01);
		wr(8'h34, 8'h01);
		wr(8'h40, 8'h1F);
		wr(8'h2E, 8'h20);
		wr(8'h10, 8'h34);
		chk("n_int", {4'h0, n_int}, 16'h0334);
		chk("odiv_commit", {13'h0, odiv}, 16'h0001);
		chk("r_div", {9'h0, dbl, r_div}, 16'h0045);
		chk("pump_pol_ofd", {10'h0, pcs, pol, ofd}, 16'h001F);
		chk("cal_busy", {15'h0, busy}, 16'h0001);
		// 155 divided ticks of 64 clk: still busy well past 9400 clk
		repeat (9400) @(posedge clk);
		rd(8'h58, 1);
		chk("cal_still_busy", d & 16'h0008, 16'h0008);
		wait_clear(3);
		chk("adc_before_fsm", d & 16'h000C, 16'h0000);
		chk("band", {7'h0, band}, 16'h01FF);
		chk("core_bias", {12'h0, core, bias}, 16'h000E);
		$display("test calibration done");
		rd(8'h5B, 2);
		chk("temp", d, 16'h01A5);
		wr(8'h45, 8'h00);
		chk("debug_pin", {15'h0, dbg}, 16'h0001);
		rd(8'h58, 1);
		chk("adc_busy", d & 16'h0004, 16'h0004);
		wait_clear(2);
		wr(8'h40, 8'h1C);
		$display("test temperature done");
		wr(8'h00, 8'h48);
		lsb_mode = 1'b1;
		rd(8'h00, 1);
		chk("four_wire_lsb", d, 16'h0048);
		rd(8'h5B, 2);
		chk("temp_lsb_stream", d, 16'h01A5);
		wr(8'h3D, 8'h20);
		chk("out_level", {15'h0, ohl}, 16'h0001);
		wr(8'h50, 8'h17);
		d = 16'h012A;
		host_u.xfer(1'b0, 15'h0051, 2, lsb_mode, d);
		chk("manual_band", {7'h0, band}, 16'h012A);
		chk("manual_core_bias", {12'h0, core, bias}, 16'h000D);
		wr(8'h00, 8'h00);
		lsb_mode = 1'b0;
		rd(8'h00, 1);
		chk("msb_restored", d, 16'h0000);
		$display("test serial_modes done");
		conclude();
	end
endmodule
`default_nettype wire

// [logic/synth_config_and_vco_cal_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - lock window profile from bits 7:5
// - debug pin chosen by 0x02E bits 7:4
// - temp ADC clocked from divided reference
// - write 0x045 starts 17-tick conversion
// - ADC busy bit 2 of 0x058
// - nine-bit result in 0x05B/0x05C
// - subordinate copy drives; main takes writes
// - write 0x010 copies main to subordinate
// - write 0x010 also starts calibration
// - unbuffered fields write subordinate directly
// - some fields always buffered, others optional
// - 0x000 bit 3 selects 3/4 wire
// - bit order msb or lsb first
// - streaming bytes go to consecutive addresses
// - calibration picks core, band, bias; manual
// - precharge then settle waits, divided clock
// - nine decisions of sixteen-times timeout each
// - ADC busy falls before state busy
// - lock after window count, drop immediately
// - select 0001 shows lock on debug pin
module synth_config_and_vco_cal_control (
	input wire logic clk,
	input wire logic srst,
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic sdo,
	output logic sdo_oe,
	input wire logic rclk,
	input wire logic phase_in_window,
	input wire logic vco_fast,
	input wire logic [8:0] temp_code,
	output logic lock_indicator_pin,
	output logic debug_out_pin,
	output logic output_high_level_sel,
	output logic [2:0] lock_window_profile,
	output logic [11:0] n_int,
	output logic [5:0] r_div,
	output logic reference_doubler_enable,
	output logic [3:0] pump_current_select,
	output logic [2:0] output_divide_ratio,
	output logic output_polarity_invert,
	output logic offset_current_direction,
	output logic [1:0] cal_clock_divide_exponent,
	output logic cal_clock_halving_mode,
	output logic vco_core_sel,
	output logic [8:0] vco_band_sel,
	output logic [2:0] vco_bias_sel,
	output logic cal_state_busy_flag
);
	logic [14:0] pin_raw, pin_meta_q, pin_sync_q;
	logic sclk_s, csb_s, sdi_s, rclk_s, win_s, fast_s;
	logic [8:0] temp_s;
	logic sclk_prev_q, rclk_prev_q, sclk_rise, sclk_fall, pfd_tick;
	logic four_wire, lsb_first;
	logic [15:0] sh_q, sh_d;
	logic [4:0] hdr_cnt_q;
	logic [2:0] bit_cnt_q;
	logic [14:0] ptr_q, rd_addr;
	logic rd_q, in_data, hdr_done, byte_done, wr_en, commit, tx_bit;
	logic [7:0] tx_q, rx_byte, rd_data;
	logic [7:0] serial_cfg_q, lock_win_q, debug_sel_q, out_lvl_q, lock_cnt_sel_q, lock_en_q;
	logic [7:0] nint_lo_q, nint_hi_q, ref_div_q, pump_q, buf_en_q, cal_div_q;
	logic [7:0] pre_lo_q, pre_hi_q, dec_to_q, set_to_q, adc_cfg_q, man_cfg_q;
	logic [8:0] man_band_q;
	logic [7:0] nint_lo_sub_q, ref_sub_q, pump_sub_q;
	logic [3:0] nint_hi_sub_q;
	logic [2:0] outdiv_sub_q;
	logic [1:0] cal_exp_sub_q;
	logic pol_sub_q, offdir_sub_q;
	logic [20:0] lock_target, lock_cnt_q;
	logic lock_q, lock_on;
	logic [2:0] div_cnt_q, div_shift, ratio_m1;
	logic cal_clk_on, cal_tick, adc_tick, adc_start, adc_busy_q;
	logic [4:0] adc_cnt_q;
	logic [8:0] temp_q;
	synth_ctrl_pkg::cal_state_t cal_state_q;
	logic [19:0] tmr_q;
	logic tmr_done;
	logic [3:0] bit_idx_q;
	logic [8:0] band_q;
	logic core_q;
	logic [2:0] bias_q;
	logic debug_q;

	// every pin input crosses two flops before use
	assign pin_raw = {temp_code, vco_fast, phase_in_window, rclk, sdio_in, csb_n, sclk};
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_q <= synth_ctrl_pkg::PIN_SYNC_RESET;
			pin_sync_q <= synth_ctrl_pkg::PIN_SYNC_RESET;
		end else begin
			pin_meta_q <= pin_raw;
			pin_sync_q <= pin_meta_q;
		end
	end
	assign sclk_s = pin_sync_q[0];
	assign csb_s = pin_sync_q[1];
	assign sdi_s = pin_sync_q[2];
	assign rclk_s = pin_sync_q[3];
	assign win_s = pin_sync_q[4];
	assign fast_s = pin_sync_q[5];
	assign temp_s = pin_sync_q[14:6];

	always_ff @(posedge clk) begin
		if (srst) begin
			sclk_prev_q <= 1'b0;
			rclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
			rclk_prev_q <= rclk_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_prev_q & ~csb_s;
	assign sclk_fall = ~sclk_s & sclk_prev_q & ~csb_s;
	assign pfd_tick = rclk_s & ~rclk_prev_q;

	// serial port: 16-bit header (rw, address) then data bytes
	assign four_wire = serial_cfg_q[synth_ctrl_pkg::SPC_FOUR_WIRE];
	assign lsb_first = serial_cfg_q[synth_ctrl_pkg::SPC_LSB_FIRST];
	// both orders leave rw in bit 15 and the address below it
	assign sh_d = lsb_first ? {sdi_s, sh_q[15:1]} : {sh_q[14:0], sdi_s};
	assign in_data = (hdr_cnt_q == synth_ctrl_pkg::HEADER_BITS);
	assign hdr_done = sclk_rise & (hdr_cnt_q == synth_ctrl_pkg::HEADER_BITS - 5'd1);
	assign byte_done = sclk_rise & in_data & (bit_cnt_q == 3'd7);
	assign rx_byte = lsb_first ? sh_d[15:8] : sh_d[7:0];
	assign wr_en = byte_done & ~rd_q;
	assign commit = wr_en & (ptr_q == synth_ctrl_pkg::ADDR_NINT_LO);
	assign rd_addr = hdr_done ? sh_d[14:0] : ptr_q + 15'd1;
	assign tx_bit = lsb_first ? tx_q[0] : tx_q[7];

	always_ff @(posedge clk) begin
		if (srst || csb_s) begin
			hdr_cnt_q <= 5'd0;
			bit_cnt_q <= 3'd0;
			rd_q <= 1'b0;
			sh_q <= 16'h0000;
			ptr_q <= 15'h0000;
		end else if (sclk_rise) begin
			sh_q <= sh_d;
			if (!in_data) begin
				hdr_cnt_q <= hdr_cnt_q + 5'd1;
			end
			if (hdr_done) begin
				rd_q <= sh_d[15];
				ptr_q <= sh_d[14:0];
				bit_cnt_q <= 3'd0;
			end else if (in_data) begin
				bit_cnt_q <= bit_cnt_q + 3'd1;
				if (byte_done) begin
					ptr_q <= ptr_q + 15'd1;
				end
			end
		end
	end

	// read data is loaded at byte boundaries and shifted on falling edges
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_q <= 8'h00;
		end else if (hdr_done || byte_done) begin
			tx_q <= rd_data;
		end else if (sclk_fall && in_data && bit_cnt_q != 3'd0) begin
			tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
		end
	end
	assign sdo = tx_bit;
	assign sdio_out = tx_bit;
	assign sdo_oe = ~csb_s & rd_q & in_data & four_wire;
	assign sdio_oe = ~csb_s & rd_q & in_data & ~four_wire;

	// buffered fields read back as their main copies
	always_comb begin
		rd_data = 8'h00;
		case (rd_addr)
			synth_ctrl_pkg::ADDR_SERIAL_CFG: rd_data = serial_cfg_q;
			synth_ctrl_pkg::ADDR_LOCK_WIN: rd_data = lock_win_q;
			synth_ctrl_pkg::ADDR_NINT_LO: rd_data = nint_lo_q;
			synth_ctrl_pkg::ADDR_NINT_HI: rd_data = nint_hi_q;
			synth_ctrl_pkg::ADDR_REF_DIV: rd_data = ref_div_q;
			synth_ctrl_pkg::ADDR_PUMP: rd_data = pump_q;
			synth_ctrl_pkg::ADDR_BUF_EN: rd_data = buf_en_q;
			synth_ctrl_pkg::ADDR_LOCK_CNT: rd_data = lock_cnt_sel_q;
			synth_ctrl_pkg::ADDR_LOCK_EN: rd_data = lock_en_q;
			synth_ctrl_pkg::ADDR_DEBUG_SEL: rd_data = debug_sel_q;
			synth_ctrl_pkg::ADDR_CAL_DIV: rd_data = cal_div_q;
			synth_ctrl_pkg::ADDR_PRE_LO: rd_data = pre_lo_q;
			synth_ctrl_pkg::ADDR_PRE_HI: rd_data = pre_hi_q;
			synth_ctrl_pkg::ADDR_DEC_TO: rd_data = dec_to_q;
			synth_ctrl_pkg::ADDR_SET_TO: rd_data = set_to_q;
			synth_ctrl_pkg::ADDR_OUT_LVL: rd_data = out_lvl_q;
			synth_ctrl_pkg::ADDR_ADC_CFG: rd_data = adc_cfg_q;
			synth_ctrl_pkg::ADDR_MAN_CFG: rd_data = man_cfg_q;
			synth_ctrl_pkg::ADDR_MAN_BAND_LO: rd_data = man_band_q[7:0];
			synth_ctrl_pkg::ADDR_MAN_BAND_HI: rd_data = {7'h00, man_band_q[8]};
			synth_ctrl_pkg::ADDR_STATUS: rd_data = {4'h0, cal_state_busy_flag, adc_busy_q, 1'b0, lock_q};
			synth_ctrl_pkg::ADDR_TEMP_LO: rd_data = temp_q[7:0];
			synth_ctrl_pkg::ADDR_TEMP_HI: rd_data = {7'h00, temp_q[8]};
			default: rd_data = 8'h00;
		endcase
	end

	// main copies and plain registers take every serial write
	always_ff @(posedge clk) begin
		if (srst) begin
			serial_cfg_q <= synth_ctrl_pkg::REG_RESET;
			lock_win_q <= synth_ctrl_pkg::REG_RESET;
			nint_lo_q <= synth_ctrl_pkg::REG_RESET;
			nint_hi_q <= synth_ctrl_pkg::REG_RESET;
			ref_div_q <= synth_ctrl_pkg::REG_RESET;
			pump_q <= synth_ctrl_pkg::REG_RESET;
			buf_en_q <= synth_ctrl_pkg::REG_RESET;
			lock_cnt_sel_q <= synth_ctrl_pkg::REG_RESET;
			lock_en_q <= synth_ctrl_pkg::REG_RESET;
			debug_sel_q <= synth_ctrl_pkg::REG_RESET;
			cal_div_q <= synth_ctrl_pkg::REG_RESET;
			pre_lo_q <= synth_ctrl_pkg::REG_RESET;
			pre_hi_q <= synth_ctrl_pkg::REG_RESET;
			dec_to_q <= synth_ctrl_pkg::REG_RESET;
			set_to_q <= synth_ctrl_pkg::REG_RESET;
			out_lvl_q <= synth_ctrl_pkg::REG_RESET;
			adc_cfg_q <= synth_ctrl_pkg::REG_RESET;
			man_cfg_q <= synth_ctrl_pkg::REG_RESET;
			man_band_q <= 9'h000;
		end else if (wr_en) begin
			case (ptr_q)
				synth_ctrl_pkg::ADDR_SERIAL_CFG: serial_cfg_q <= rx_byte;
				synth_ctrl_pkg::ADDR_LOCK_WIN: lock_win_q <= rx_byte;
				synth_ctrl_pkg::ADDR_NINT_LO: nint_lo_q <= rx_byte;
				synth_ctrl_pkg::ADDR_NINT_HI: nint_hi_q <= rx_byte;
				synth_ctrl_pkg::ADDR_REF_DIV: ref_div_q <= rx_byte;
				synth_ctrl_pkg::ADDR_PUMP: pump_q <= rx_byte;
				synth_ctrl_pkg::ADDR_BUF_EN: buf_en_q <= rx_byte;
				synth_ctrl_pkg::ADDR_LOCK_CNT: lock_cnt_sel_q <= rx_byte;
				synth_ctrl_pkg::ADDR_LOCK_EN: lock_en_q <= rx_byte;
				synth_ctrl_pkg::ADDR_DEBUG_SEL: debug_sel_q <= rx_byte;
				synth_ctrl_pkg::ADDR_CAL_DIV: cal_div_q <= rx_byte;
				synth_ctrl_pkg::ADDR_PRE_LO: pre_lo_q <= rx_byte;
				synth_ctrl_pkg::ADDR_PRE_HI: pre_hi_q <= rx_byte;
				synth_ctrl_pkg::ADDR_DEC_TO: dec_to_q <= rx_byte;
				synth_ctrl_pkg::ADDR_SET_TO: set_to_q <= rx_byte;
				synth_ctrl_pkg::ADDR_OUT_LVL: out_lvl_q <= rx_byte;
				synth_ctrl_pkg::ADDR_ADC_CFG: adc_cfg_q <= rx_byte;
				synth_ctrl_pkg::ADDR_MAN_CFG: man_cfg_q <= rx_byte;
				synth_ctrl_pkg::ADDR_MAN_BAND_LO: man_band_q[7:0] <= rx_byte;
				synth_ctrl_pkg::ADDR_MAN_BAND_HI: man_band_q[8] <= rx_byte[0];
				default: ;
			endcase
		end
	end

	// subordinate copies: these steer the synthesizer, except cal_clock_halving_mode, which follows the main copy
	always_ff @(posedge clk) begin
		if (srst) begin
			nint_lo_sub_q <= synth_ctrl_pkg::REG_RESET;
			nint_hi_sub_q <= 4'h0;
			ref_sub_q <= synth_ctrl_pkg::REG_RESET;
			pump_sub_q <= synth_ctrl_pkg::REG_RESET;
			outdiv_sub_q <= 3'h0;
			pol_sub_q <= 1'b0;
			cal_exp_sub_q <= 2'h0;
			offdir_sub_q <= 1'b0;
		end else if (commit) begin
			nint_lo_sub_q <= rx_byte;
			nint_hi_sub_q <= nint_hi_q[3:0];
			ref_sub_q <= ref_div_q;
			pump_sub_q <= pump_q;
			outdiv_sub_q <= nint_hi_q[synth_ctrl_pkg::NHI_DIV_MSB:synth_ctrl_pkg::NHI_DIV_LSB];
			pol_sub_q <= nint_hi_q[synth_ctrl_pkg::NHI_POL];
			cal_exp_sub_q <= cal_div_q[1:0];
			offdir_sub_q <= buf_en_q[synth_ctrl_pkg::BUF_OFF_DIR];
		end else if (wr_en) begin
			// buffered writes leave the subordinate copy alone
			if (ptr_q == synth_ctrl_pkg::ADDR_NINT_HI) begin
				if (!buf_en_q[synth_ctrl_pkg::BUF_OUT_DB]) begin
					outdiv_sub_q <= rx_byte[7:5];
				end
				if (!buf_en_q[synth_ctrl_pkg::BUF_DEL_DB]) begin
					pol_sub_q <= rx_byte[synth_ctrl_pkg::NHI_POL];
				end
			end
			if (ptr_q == synth_ctrl_pkg::ADDR_CAL_DIV && !buf_en_q[synth_ctrl_pkg::BUF_CAL_DB]) begin
				cal_exp_sub_q <= rx_byte[1:0];
			end
			// the enable written in the same byte governs its own field
			if (ptr_q == synth_ctrl_pkg::ADDR_BUF_EN && !rx_byte[synth_ctrl_pkg::BUF_DEL_DB]) begin
				offdir_sub_q <= rx_byte[synth_ctrl_pkg::BUF_OFF_DIR];
			end
		end
	end
	assign n_int = {nint_hi_sub_q, nint_lo_sub_q};
	assign r_div = ref_sub_q[5:0];
	assign reference_doubler_enable = ref_sub_q[synth_ctrl_pkg::REF_DBL];
	assign pump_current_select = pump_sub_q[3:0];
	assign output_divide_ratio = outdiv_sub_q;
	assign output_polarity_invert = pol_sub_q;
	assign offset_current_direction = offdir_sub_q;
	assign cal_clock_divide_exponent = cal_exp_sub_q;
	assign cal_clock_halving_mode = cal_div_q[synth_ctrl_pkg::CAL_MODE];
	assign lock_window_profile = lock_win_q[synth_ctrl_pkg::LW_MSB:synth_ctrl_pkg::LW_LSB];
	assign output_high_level_sel = out_lvl_q[synth_ctrl_pkg::OUT_LVL_BIT];

	// lock counts in window: odd codes 2^(k+5)+3, even codes 3*2^(k+3)+3
	always_comb begin
		if (lock_cnt_sel_q[0]) begin
			lock_target = (21'h1 << ({1'b0, lock_cnt_sel_q[4:1]} + 5'd5)) + 21'h3;
		end else begin
			lock_target = (21'h3 << ({1'b0, lock_cnt_sel_q[4:1]} + 5'd3)) + 21'h3;
		end
	end
	assign lock_on = lock_en_q[synth_ctrl_pkg::LOCK_EN_LOL] & lock_en_q[synth_ctrl_pkg::LOCK_EN_WIN];
	always_ff @(posedge clk) begin
		if (srst || !lock_on || !win_s) begin
			lock_cnt_q <= 21'h0;
			lock_q <= 1'b0;
		end else if (pfd_tick && !lock_q) begin
			lock_cnt_q <= lock_cnt_q + 21'h1;
			if (lock_cnt_q + 21'h1 >= lock_target) begin
				lock_q <= 1'b1;
			end
		end
	end
	assign lock_indicator_pin = lock_q;

	// divided calibration clock, also the temperature ADC clock
	assign cal_clk_on = adc_cfg_q[synth_ctrl_pkg::ADC_REF_CLK] & adc_cfg_q[synth_ctrl_pkg::ADC_FB_CLK];
	assign div_shift = {1'b0, cal_exp_sub_q} + {2'b00, cal_clock_halving_mode};
	assign ratio_m1 = 3'((4'h1 << div_shift) - 4'h1);
	assign cal_tick = pfd_tick & cal_clk_on & (div_cnt_q == ratio_m1);
	always_ff @(posedge clk) begin
		if (srst || !cal_clk_on) begin
			div_cnt_q <= 3'h0;
		end else if (pfd_tick) begin
			div_cnt_q <= (div_cnt_q == ratio_m1) ? 3'h0 : div_cnt_q + 3'h1;
		end
	end

	// ADC stalls without its enables; host must keep this clock <= 400 kHz
	assign adc_tick = cal_tick & adc_cfg_q[synth_ctrl_pkg::ADC_CONV] & adc_cfg_q[synth_ctrl_pkg::ADC_EN]
		& adc_cfg_q[synth_ctrl_pkg::ADC_CLK_EN] & ~adc_cfg_q[synth_ctrl_pkg::ADC_PD];
	assign adc_start = (wr_en & (ptr_q == synth_ctrl_pkg::ADDR_TEMP_TRIG)) | commit;
	always_ff @(posedge clk) begin
		if (srst) begin
			adc_busy_q <= 1'b0;
			adc_cnt_q <= 5'd0;
			temp_q <= 9'h000;
		end else if (adc_start) begin
			adc_busy_q <= 1'b1;
			adc_cnt_q <= 5'd0;
		end else if (adc_busy_q && adc_tick) begin
			if (adc_cnt_q == synth_ctrl_pkg::ADC_CONV_TICKS - 5'd1) begin
				adc_busy_q <= 1'b0;
				temp_q <= temp_s;
			end else begin
				adc_cnt_q <= adc_cnt_q + 5'd1;
			end
		end
	end

	// calibration: precharge, nine trial bits each decided then settled
	assign tmr_done = cal_tick & (tmr_q <= 20'h1);
	always_ff @(posedge clk) begin
		if (srst) begin
			cal_state_q <= synth_ctrl_pkg::CAL_IDLE;
			tmr_q <= 20'h0;
			bit_idx_q <= 4'h0;
			band_q <= 9'h000;
			core_q <= 1'b0;
			bias_q <= 3'h0;
			cal_state_busy_flag <= 1'b0;
		end else if (commit) begin
			cal_state_q <= synth_ctrl_pkg::CAL_PRECHARGE;
			tmr_q <= {4'h0, pre_hi_q, pre_lo_q};
			band_q <= 9'h000;
			cal_state_busy_flag <= 1'b1;
		end else begin
			if (cal_tick && !tmr_done) begin
				tmr_q <= tmr_q - 20'h1;
			end
			unique case (cal_state_q)
				synth_ctrl_pkg::CAL_IDLE: ;
				synth_ctrl_pkg::CAL_PRECHARGE: if (tmr_done) begin
					core_q <= fast_s;
					bit_idx_q <= synth_ctrl_pkg::BAND_LAST_BIT;
					band_q[synth_ctrl_pkg::BAND_LAST_BIT] <= 1'b1;
					tmr_q <= {8'h00, dec_to_q, 4'h0};
					cal_state_q <= synth_ctrl_pkg::CAL_DECIDE;
				end
				synth_ctrl_pkg::CAL_DECIDE: if (tmr_done) begin
					if (!fast_s) begin
						band_q[bit_idx_q] <= 1'b0;
					end
					tmr_q <= {12'h000, set_to_q};
					cal_state_q <= synth_ctrl_pkg::CAL_SETTLE;
				end
				synth_ctrl_pkg::CAL_SETTLE: if (tmr_done) begin
					if (bit_idx_q == 4'h0) begin
						cal_state_q <= synth_ctrl_pkg::CAL_FINISH;
					end else begin
						bit_idx_q <= bit_idx_q - 4'h1;
						band_q[bit_idx_q - 4'h1] <= 1'b1;
						tmr_q <= {8'h00, dec_to_q, 4'h0};
						cal_state_q <= synth_ctrl_pkg::CAL_DECIDE;
					end
				end
				synth_ctrl_pkg::CAL_FINISH: if (!adc_busy_q) begin
					// bias follows die temperature, so wait for the conversion
					bias_q <= temp_q[8:6];
					cal_state_busy_flag <= 1'b0;
					cal_state_q <= synth_ctrl_pkg::CAL_IDLE;
				end
			endcase
		end
	end
	assign vco_core_sel = man_cfg_q[synth_ctrl_pkg::MAN_EN] ? man_cfg_q[synth_ctrl_pkg::MAN_CORE] : core_q;
	assign vco_band_sel = man_cfg_q[synth_ctrl_pkg::MAN_EN] ? man_band_q : band_q;
	assign vco_bias_sel = man_cfg_q[synth_ctrl_pkg::MAN_EN] ? man_cfg_q[4:2] : bias_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			debug_q <= 1'b0;
		end else begin
			case (debug_sel_q[synth_ctrl_pkg::DBG_MSB:synth_ctrl_pkg::DBG_LSB])
				synth_ctrl_pkg::MUX_SEL_LOCK: debug_q <= lock_q;
				synth_ctrl_pkg::MUX_SEL_ADC_BUSY: debug_q <= adc_busy_q;
				synth_ctrl_pkg::MUX_SEL_CAL_BUSY: debug_q <= cal_state_busy_flag;
				synth_ctrl_pkg::MUX_SEL_CAL_TICK: debug_q <= cal_tick;
				default: debug_q <= 1'b0;
			endcase
		end
	end
	assign debug_out_pin = debug_q;

	a_adc_busy_start: assert property (@(posedge clk) disable iff (srst) adc_start |=> adc_busy_q) else $error("adc busy not set");
	a_adc_seventeen: assert property (@(posedge clk) disable iff (srst)
		$fell(adc_busy_q) |-> $past(adc_cnt_q) == 5'd16 && $past(adc_tick)) else $error("adc length wrong");
	a_temp_store: assert property (@(posedge clk) disable iff (srst)
		$fell(adc_busy_q) |-> temp_q == $past(temp_s)) else $error("temp not stored");
	a_commit_copy: assert property (@(posedge clk) disable iff (srst)
		commit |=> n_int[11:8] == $past(nint_hi_q[3:0]) && pump_current_select == $past(pump_q[3:0])) else $error("commit copy missing");
	a_buffer_hold: assert property (@(posedge clk) disable iff (srst)
		wr_en && ptr_q == synth_ctrl_pkg::ADDR_PUMP |=> $stable(pump_current_select)) else $error("buffered field changed");
	a_unbuf_direct: assert property (@(posedge clk) disable iff (srst)
		wr_en && ptr_q == synth_ctrl_pkg::ADDR_NINT_HI && !buf_en_q[synth_ctrl_pkg::BUF_OUT_DB]
		|=> output_divide_ratio == $past(rx_byte[7:5])) else $error("direct write missed");
	a_cal_start: assert property (@(posedge clk) disable iff (srst)
		commit |=> cal_state_busy_flag && cal_state_q == synth_ctrl_pkg::CAL_PRECHARGE) else $error("cal not started");
	a_busy_order: assert property (@(posedge clk) disable iff (srst)
		$fell(cal_state_busy_flag) |-> !$past(adc_busy_q) && $past(bit_idx_q) == 4'h0) else $error("busy order wrong");
	a_lock_drop: assert property (@(posedge clk) disable iff (srst) lock_q && !win_s |=> !lock_q) else $error("lock held");
	a_mux_lock: assert property (@(posedge clk) disable iff (srst)
		debug_sel_q[7:4] == 4'h1 [*2] |-> debug_out_pin == $past(lock_q)) else $error("mux not lock");
	a_wire_mode: assert property (@(posedge clk) disable iff (srst) !(sdo_oe && sdio_oe)) else $error("both drivers on");
endmodule
`default_nettype wire

// [logic/synth_ctrl_pkg.sv]
`default_nettype none
package synth_ctrl_pkg;
	// register offsets
	localparam logic [14:0] ADDR_SERIAL_CFG = 15'h0000;
	localparam logic [14:0] ADDR_LOCK_WIN = 15'h0002;
	localparam logic [14:0] ADDR_NINT_LO = 15'h0010;
	localparam logic [14:0] ADDR_NINT_HI = 15'h0011;
	localparam logic [14:0] ADDR_REF_DIV = 15'h0020;
	localparam logic [14:0] ADDR_PUMP = 15'h0021;
	localparam logic [14:0] ADDR_BUF_EN = 15'h0022;
	localparam logic [14:0] ADDR_LOCK_CNT = 15'h002C;
	localparam logic [14:0] ADDR_LOCK_EN = 15'h002D;
	localparam logic [14:0] ADDR_DEBUG_SEL = 15'h002E;
	localparam logic [14:0] ADDR_CAL_DIV = 15'h0030;
	localparam logic [14:0] ADDR_PRE_LO = 15'h0031;
	localparam logic [14:0] ADDR_PRE_HI = 15'h0032;
	localparam logic [14:0] ADDR_DEC_TO = 15'h0033;
	localparam logic [14:0] ADDR_SET_TO = 15'h0034;
	localparam logic [14:0] ADDR_OUT_LVL = 15'h003D;
	localparam logic [14:0] ADDR_ADC_CFG = 15'h0040;
	localparam logic [14:0] ADDR_TEMP_TRIG = 15'h0045;
	localparam logic [14:0] ADDR_MAN_CFG = 15'h0050;
	localparam logic [14:0] ADDR_MAN_BAND_LO = 15'h0051;
	localparam logic [14:0] ADDR_MAN_BAND_HI = 15'h0052;
	localparam logic [14:0] ADDR_STATUS = 15'h0058;
	localparam logic [14:0] ADDR_TEMP_LO = 15'h005B;
	localparam logic [14:0] ADDR_TEMP_HI = 15'h005C;
	// field positions
	localparam int SPC_FOUR_WIRE = 3;
	localparam int SPC_LSB_FIRST = 6;
	localparam int LW_MSB = 7;
	localparam int LW_LSB = 5;
	localparam int DBG_MSB = 7;
	localparam int DBG_LSB = 4;
	localparam int OUT_LVL_BIT = 5;
	localparam int NHI_POL = 4;
	localparam int NHI_DIV_MSB = 7;
	localparam int NHI_DIV_LSB = 5;
	localparam int REF_DBL = 6;
	localparam int BUF_OUT_DB = 0;
	localparam int BUF_CAL_DB = 1;
	localparam int BUF_DEL_DB = 2;
	localparam int BUF_OFF_DIR = 4;
	localparam int LOCK_EN_LOL = 5;
	localparam int LOCK_EN_WIN = 4;
	localparam int CAL_MODE = 2;
	localparam int ADC_REF_CLK = 0;
	localparam int ADC_FB_CLK = 1;
	localparam int ADC_CONV = 2;
	localparam int ADC_EN = 3;
	localparam int ADC_CLK_EN = 4;
	localparam int ADC_PD = 5;
	localparam int MAN_EN = 0;
	localparam int MAN_CORE = 1;
	// reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [14:0] PIN_SYNC_RESET = 15'h0002;
	// timing and encodings
	localparam logic [4:0] ADC_CONV_TICKS = 5'd17;
	localparam logic [3:0] BAND_LAST_BIT = 4'd8;
	localparam logic [4:0] HEADER_BITS = 5'd16;
	localparam logic [3:0] MUX_SEL_LOCK = 4'h1;
	localparam logic [3:0] MUX_SEL_ADC_BUSY = 4'h2;
	localparam logic [3:0] MUX_SEL_CAL_BUSY = 4'h3;
	localparam logic [3:0] MUX_SEL_CAL_TICK = 4'h4;
	typedef enum logic [2:0] {CAL_IDLE, CAL_PRECHARGE, CAL_DECIDE, CAL_SETTLE, CAL_FINISH} cal_state_t;
endpackage
`default_nettype wire
